// ===== hdl/tlas_i2c_slave.sv
// Two-wire register slave with pin-selected address and bleed controls
`timescale 1ns/1ps
`default_nettype none
module tlas_i2c_slave
    import tlas_pkg::*;
#(
    parameter int REG_COUNT = REG_COUNT_DEF
) (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe_out,
    input wire tlas_tri_pin_type addr_sel_pin0_in,
    input wire tlas_tri_pin_type addr_sel_pin1_in,
    input wire tlas_tri_pin_type addr_sel_pin2_in,
    input wire logic chan_12v_a_on_in,
    input wire logic chan_12v_b_on_in,
    output logic bleed_en_12v_a_out,
    output logic bleed_en_12v_b_out,
    output logic bleed_sw_12v_a_out,
    output logic bleed_sw_12v_b_out,
    output logic [6:0] dev_addr_out
);
    localparam int IDX_W = (REG_COUNT > 1) ? $clog2(REG_COUNT) : 1;

    // Link side: one sample per rising SCL edge
    logic lnk_bit_reg;
    logic lnk_tgl_reg;

    always_ff @(posedge scl_in or posedge rst_in) begin
        if (rst_in) begin
            lnk_bit_reg <= 1'b0;
            lnk_tgl_reg <= 1'b0;
        end else begin
            lnk_bit_reg <= sda_in;
            lnk_tgl_reg <= ~lnk_tgl_reg;
        end
    end

    // Crossings into the system clock
    logic tgl_s;
    logic tgl_prev_reg;
    tlas_bus_type bus_s;
    tlas_bus_type bus_prev_reg;

    tlas_sync #(.WIDTH(1)) u_tgl_sync (
        .clk_in(clk_in),
        .rst_in(rst_in),
        .d_in(lnk_tgl_reg),
        .q_out(tgl_s)
    );

    tlas_sync #(.WIDTH(2)) u_bus_sync (
        .clk_in(clk_in),
        .rst_in(rst_in),
        .d_in({scl_in, sda_in}),
        .q_out(bus_s)
    );

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            tgl_prev_reg <= 1'b0;
            bus_prev_reg <= '0;
        end else begin
            tgl_prev_reg <= tgl_s;
            bus_prev_reg <= bus_s;
        end
    end

    // Sampled bit is held until the next rising edge, read once the toggle lands
    wire bit_evt = tgl_s ^ tgl_prev_reg;
    wire scl_fall = bus_prev_reg.scl & ~bus_s.scl;
    wire start_evt = bus_s.scl & bus_prev_reg.scl & bus_prev_reg.sda & ~bus_s.sda;
    wire stop_evt = bus_s.scl & bus_prev_reg.scl & ~bus_prev_reg.sda & bus_s.sda;

    // Pin-selected address
    tlas_level_type lvl0;
    tlas_level_type lvl1;
    tlas_level_type lvl2;
    logic [6:0] dev_addr_next;

    tlas_tri_level u_pin0 (.clk_in(clk_in), .rst_in(rst_in), .pin_in(addr_sel_pin0_in),
        .level_out(lvl0));
    tlas_tri_level u_pin1 (.clk_in(clk_in), .rst_in(rst_in), .pin_in(addr_sel_pin1_in),
        .level_out(lvl1));
    tlas_tri_level u_pin2 (.clk_in(clk_in), .rst_in(rst_in), .pin_in(addr_sel_pin2_in),
        .level_out(lvl2));

    assign dev_addr_next = ADDR_BASE + W_PIN2 * 7'(lvl2) + W_PIN1 * 7'(lvl1)
                           + 7'(lvl0);

    // Protocol state
    tlas_state_type state_reg, state_next;
    logic [7:0] shift_reg, shift_next;
    logic [3:0] cnt_reg, cnt_next;
    logic ph_reg, ph_next;
    logic rw_reg, rw_next;
    logic [7:0] ptr_reg, ptr_next;
    logic sda_oe_next;
    wire sda_oe_reg = sda_oe_out;
    logic [7:0] regs [REG_COUNT];

    wire [7:0] rx_byte = {shift_reg[6:0], lnk_bit_reg};
    wire last_bit = bit_evt & (cnt_reg == LAST_BIT);
    wire addr_hit = (rx_byte[7:1] == dev_addr_out);
    wire ptr_ok = (ptr_reg < 8'(REG_COUNT));
    wire [IDX_W-1:0] ptr_idx = ptr_reg[IDX_W-1:0];
    wire [7:0] rd_data = ptr_ok ? regs[ptr_idx] : 8'h00;
    wire wr_en = (state_reg == ST_DATA) & last_bit & ptr_ok;
    wire in_ack = (state_reg == ST_ADDR_ACK) | (state_reg == ST_REG_ACK)
                  | (state_reg == ST_DATA_ACK);

    always_comb begin
        state_next = state_reg;
        shift_next = shift_reg;
        cnt_next = cnt_reg;
        ph_next = ph_reg;
        rw_next = rw_reg;
        ptr_next = ptr_reg;
        sda_oe_next = sda_oe_reg;
        if (stop_evt) begin
            state_next = ST_IDLE;
            sda_oe_next = 1'b0;
        end else if (start_evt) begin
            state_next = ST_ADDR;
            cnt_next = 4'h0;
            sda_oe_next = 1'b0;
        end else begin
            case (state_reg)
                ST_ADDR, ST_REG, ST_DATA: begin
                    if (bit_evt) begin
                        shift_next = rx_byte;
                        cnt_next = cnt_reg + 4'h1;
                    end
                    if (last_bit) begin
                        ph_next = 1'b0;
                        if (state_reg == ST_ADDR) begin
                            rw_next = rx_byte[0];
                            state_next = addr_hit ? ST_ADDR_ACK : ST_IGNORE;
                        end else if (state_reg == ST_REG) begin
                            ptr_next = rx_byte;
                            state_next = ST_REG_ACK;
                        end else begin
                            state_next = ST_DATA_ACK;
                        end
                    end
                end
                ST_ADDR_ACK, ST_REG_ACK, ST_DATA_ACK: begin
                    if (bit_evt) begin
                        ph_next = 1'b1;
                    end
                    if (scl_fall && !ph_reg) begin
                        sda_oe_next = 1'b1;
                    end else if (scl_fall) begin
                        sda_oe_next = 1'b0;
                        cnt_next = 4'h0;
                        if (state_reg == ST_ADDR_ACK && rw_reg) begin
                            state_next = ST_TX;
                            shift_next = rd_data;
                            sda_oe_next = ~rd_data[7];
                        end else if (state_reg == ST_ADDR_ACK) begin
                            state_next = ST_REG;
                        end else if (state_reg == ST_REG_ACK) begin
                            state_next = ST_DATA;
                        end else begin
                            state_next = ST_IGNORE;
                        end
                    end
                end
                ST_TX: begin
                    if (bit_evt) begin
                        cnt_next = cnt_reg + 4'h1;
                    end
                    if (last_bit) begin
                        state_next = ST_TX_ACK;
                        ph_next = 1'b0;
                    end else if (scl_fall && cnt_reg != 4'h0) begin
                        shift_next = {shift_reg[6:0], 1'b0};
                        sda_oe_next = ~shift_reg[6];
                    end
                end
                ST_TX_ACK: begin
                    if (scl_fall) begin
                        sda_oe_next = 1'b0;
                    end
                    if (bit_evt) begin
                        state_next = ST_IGNORE;
                    end
                end
                ST_IGNORE: begin
                    sda_oe_next = 1'b0;
                end
                default: begin
                    state_next = ST_IDLE;
                    sda_oe_next = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            state_reg <= ST_IDLE;
            shift_reg <= 8'h00;
            cnt_reg <= 4'h0;
            ph_reg <= 1'b0;
            rw_reg <= 1'b0;
            ptr_reg <= 8'h00;
            sda_oe_out <= 1'b0;
            dev_addr_out <= ADDR_BASE;
        end else begin
            state_reg <= state_next;
            shift_reg <= shift_next;
            cnt_reg <= cnt_next;
            ph_reg <= ph_next;
            rw_reg <= rw_next;
            ptr_reg <= ptr_next;
            sda_oe_out <= sda_oe_next;
            dev_addr_out <= dev_addr_next;
        end
    end


    // Open-drain: only ever pulls low
    assign sda_out = 1'b0;

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            for (int i = 0; i < REG_COUNT; i++) begin
                regs[i] <= REG_RESET;
            end
        end else if (wr_en) begin
            regs[ptr_idx] <= rx_byte;
        end
    end

    // Bleed switches close only while the channel is off
    wire [7:0] reg_a = regs[REG_BLEED_A[IDX_W-1:0]];
    wire [7:0] reg_b = regs[REG_BLEED_B[IDX_W-1:0]];

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            bleed_en_12v_a_out <= 1'b0;
            bleed_en_12v_b_out <= 1'b0;
            bleed_sw_12v_a_out <= 1'b0;
            bleed_sw_12v_b_out <= 1'b0;
        end else begin
            bleed_en_12v_a_out <= reg_a[BLEED_BIT];
            bleed_en_12v_b_out <= reg_b[BLEED_BIT];
            bleed_sw_12v_a_out <= reg_a[BLEED_BIT] & ~chan_12v_a_on_in;
            bleed_sw_12v_b_out <= reg_b[BLEED_BIT] & ~chan_12v_b_on_in;
        end
    end

    default clocking cb @(posedge clk_in); endclocking
    default disable iff (rst_in);

    a_addr_formula: assert property (
        dev_addr_out == ADDR_BASE + W_PIN2 * 7'($past(lvl2)) + W_PIN1 * 7'($past(lvl1))
                        + 7'($past(lvl0)))
        else $error("device address does not follow pin levels");

    a_addr_range: assert property (
        dev_addr_out >= ADDR_BASE && dev_addr_out <= ADDR_LAST)
        else $error("device address out of its 27-value range");

    a_start_resets: assert property (
        start_evt && !stop_evt |=> state_reg == ST_ADDR && cnt_reg == 4'h0 && !sda_oe_reg)
        else $error("start did not open address phase");

    a_stop_idle: assert property (
        stop_evt |=> state_reg == ST_IDLE && !sda_oe_reg)
        else $error("stop did not release the bus");

    a_nack_mismatch: assert property (
        state_reg == ST_ADDR && last_bit && !addr_hit && !start_evt && !stop_evt
        |=> state_reg == ST_IGNORE && !sda_oe_reg)
        else $error("foreign address was not ignored");

    a_ignore_silent: assert property (
        (state_reg == ST_IGNORE || state_reg == ST_IDLE) && $past(state_reg) == state_reg
        |-> !sda_oe_reg)
        else $error("data line driven outside an owned phase");

    a_ack_drive: assert property (
        in_ack && !ph_reg && scl_fall && !start_evt && !stop_evt |=> sda_oe_reg)
        else $error("acknowledge not driven");

    a_write_load: assert property (
        wr_en |=> regs[$past(ptr_idx)] == $past(rx_byte))
        else $error("written data not loaded");

    a_tx_msb: assert property (
        state_reg == ST_ADDR_ACK && rw_reg && ph_reg && scl_fall && !start_evt && !stop_evt
        |=> state_reg == ST_TX && sda_oe_reg == !$past(rd_data[7]))
        else $error("read byte did not start with its top bit");

    a_bleed_sw: assert property (
        ##1 bleed_sw_12v_a_out == ($past(reg_a[BLEED_BIT]) && !$past(chan_12v_a_on_in)))
        else $error("bleed switch A wrong");

    c_write: cover property (wr_en ##[1:200] stop_evt);
    c_read: cover property (state_reg == ST_TX_ACK ##[1:200] state_reg == ST_IGNORE);
    c_foreign: cover property (state_reg == ST_ADDR ##1 state_reg == ST_IGNORE);
    c_bleed: cover property (bleed_sw_12v_b_out);
endmodule
`default_nettype wire

// ===== hdl/tlas_pkg.sv
// Shared constants and types for the tri-level addressed serial register slave
// Notes on behaviour
// - Follow two-wire bus timing and protocol, up to high-speed mode.
// - Answer exactly one of 27 seven-bit addresses chosen by three pins.
// - Each select pin reads low, high or floating as three distinct levels.
// - Address is 8 + 9*pin2 + 3*pin1 + pin0, low=0, float=1, high=2.
// - Slave only; never starts transfers; single register write and read.
// - Acknowledge address, register number and data, then load the register; the code loads on the eighth data bit, before the data acknowledge.
// - After acking read address, drive selected register out, MSB first.
// - Bleed resistor on while channel off and its enable bit is set.
package tlas_pkg;
    localparam logic [6:0] ADDR_BASE = 7'h08;
    localparam logic [6:0] ADDR_LAST = 7'h22;
    localparam logic [6:0] W_PIN2 = 7'h09;
    localparam logic [6:0] W_PIN1 = 7'h03;
    localparam logic [7:0] REG_BLEED_A = 8'h01;
    localparam logic [7:0] REG_BLEED_B = 8'h04;
    localparam int BLEED_BIT = 7;
    localparam int REG_COUNT_DEF = 8;
    localparam logic [7:0] REG_RESET = 8'h00;
    localparam logic [3:0] LAST_BIT = 4'h7;
    localparam int SYNC_STAGES = 2;

    typedef enum logic [1:0] {LVL_LOW, LVL_NC, LVL_HIGH} tlas_level_type;

    // Comparator pair watching one select pin
    typedef struct packed {
        logic above_hi;
        logic below_lo;
    } tlas_tri_pin_type;

    // Synchronised bus lines
    typedef struct packed {
        logic scl;
        logic sda;
    } tlas_bus_type;

    typedef enum logic [3:0] {
        ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_REG, ST_REG_ACK,
        ST_DATA, ST_DATA_ACK, ST_TX, ST_TX_ACK, ST_IGNORE
    } tlas_state_type;
endpackage

// ===== hdl/tlas_sync.sv
// Two-stage synchroniser for asynchronous levels
`timescale 1ns/1ps
`default_nettype none
module tlas_sync #(
    parameter int WIDTH = 1
) (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic [WIDTH-1:0] d_in,
    output logic [WIDTH-1:0] q_out
);
    logic [WIDTH-1:0] meta_reg;

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            meta_reg <= '0;
            q_out <= '0;
        end else begin
            meta_reg <= d_in;
            q_out <= meta_reg;
        end
    end
endmodule
`default_nettype wire

// ===== hdl/tlas_tri_level.sv
// Three-level decoder for one address select pin
`timescale 1ns/1ps
`default_nettype none
module tlas_tri_level
    import tlas_pkg::*;
(
    input wire logic clk_in,
    input wire logic rst_in,
    input wire tlas_tri_pin_type pin_in,
    output tlas_level_type level_out
);
    tlas_tri_pin_type pin_s;
    tlas_level_type level_next;

    tlas_sync #(.WIDTH(2)) u_sync (
        .clk_in(clk_in),
        .rst_in(rst_in),
        .d_in(pin_in),
        .q_out(pin_s)
    );

    // Grounded, tied to supply, or left floating
    assign level_next = pin_s.below_lo ? LVL_LOW :
                        (pin_s.above_hi ? LVL_HIGH : LVL_NC);

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            level_out <= LVL_LOW;
        end else begin
            level_out <= level_next;
        end
    end

    a_level_map: assert property (@(posedge clk_in) disable iff (rst_in)
        !$past(rst_in) |->
        level_out == ($past(pin_s.below_lo) ? LVL_LOW :
                      ($past(pin_s.above_hi) ? LVL_HIGH : LVL_NC)))
        else $error("select pin level decoded wrongly");
endmodule
`default_nettype wire

// ===== verification/tlas_i2c_master_model.sv
// Behavioural two-wire bus master driving the register slave
`timescale 1ns/1ps
`default_nettype none
module tlas_i2c_master_model (
    output logic scl_out,
    output logic sda_pull_out,
    input wire logic sda_in
);
    // Six link ticks of 48 ns keep each SCL phase above 250 ns
    localparam int HALF = 6;
    logic tick;

    initial begin
        tick = 1'b0;
        forever #24 tick = ~tick;
    end

    initial begin
        scl_out = 1'b1;
        sda_pull_out = 1'b0;
    end

    task automatic wait_ticks(input int n);
        repeat (n) @(posedge tick);
    endtask

    // Data changes only while SCL is low, sampled late in the high phase
    task automatic bit_cycle(input logic pull, output logic seen);
        wait_ticks(1);
        sda_pull_out = pull;
        wait_ticks(HALF - 1);
        scl_out = 1'b1;
        wait_ticks(HALF);
        seen = sda_in;
        scl_out = 1'b0;
    endtask

    task automatic start_cond();
        wait_ticks(HALF);
        sda_pull_out = 1'b1;
        wait_ticks(HALF);
        scl_out = 1'b0;
    endtask

    task automatic restart_cond();
        wait_ticks(1);
        sda_pull_out = 1'b0;
        wait_ticks(HALF - 1);
        scl_out = 1'b1;
        wait_ticks(HALF);
        sda_pull_out = 1'b1;
        wait_ticks(HALF);
        scl_out = 1'b0;
    endtask

    task automatic stop_cond();
        wait_ticks(1);
        sda_pull_out = 1'b1;
        wait_ticks(HALF - 1);
        scl_out = 1'b1;
        wait_ticks(HALF);
        sda_pull_out = 1'b0;
        wait_ticks(HALF);
    endtask

    task automatic send_byte(input logic [7:0] d, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_cycle(~d[i], s);
        end
        bit_cycle(1'b0, s);
        ack = ~s;
    endtask

    task automatic recv_byte(output logic [7:0] d);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_cycle(1'b0, s);
            d[i] = s;
        end
        bit_cycle(1'b1, s);
    endtask

    task automatic write_reg(input logic [6:0] addr, input logic [7:0] num,
                             input logic [7:0] data, output logic [2:0] acks);
        start_cond();
        send_byte({addr, 1'b0}, acks[2]);
        send_byte(num, acks[1]);
        send_byte(data, acks[0]);
        stop_cond();
    endtask

    task automatic read_reg(input logic [6:0] addr, input logic [7:0] num,
                            output logic [7:0] data, output logic [2:0] acks);
        start_cond();
        send_byte({addr, 1'b0}, acks[2]);
        send_byte(num, acks[1]);
        restart_cond();
        send_byte({addr, 1'b1}, acks[0]);
        recv_byte(data);
        stop_cond();
    endtask
endmodule
`default_nettype wire

// ===== verification/tlas_i2c_slave_tb.sv
// Self-checking bench for the tri-level addressed register slave
`timescale 1ns/1ps
`default_nettype none
module tri_level_addr_i2c_reg_slave_tb_top
    import tlas_pkg::*;
;
    logic clk_in, rst_in, scl, sda_pull, sda_wire, chan_a, chan_b;
    logic sda_out, sda_oe, en_a, en_b, sw_a, sw_b;
    tlas_tri_pin_type pin0, pin1, pin2;
    logic [6:0] dev_addr, a;
    logic [7:0] num, dat, got;
    logic [2:0] acks;
    logic [31:0] lfsr_state, r;
    int fail_count, num_checks, k, l0, l1, l2;
    logic [7:0] tab_r1 [4] = '{8'h80, 8'h80, 8'h7F, 8'hFF};
    logic [7:0] tab_r4 [4] = '{8'h00, 8'hFF, 8'h7F, 8'hFF};
    logic tab_ca [4] = '{1'b0, 1'b1, 1'b0, 1'b0};
    logic tab_cb [4] = '{1'b0, 1'b0, 1'b1, 1'b1};

    // Open-drain wire with pull-up
    assign sda_wire = ~(sda_pull | (sda_oe & ~sda_out));

    tlas_i2c_slave #(.REG_COUNT(8)) u_tlas_i2c_slave (
        .clk_in(clk_in), .rst_in(rst_in), .scl_in(scl), .sda_in(sda_wire),
        .sda_out(sda_out), .sda_oe_out(sda_oe),
        .addr_sel_pin0_in(pin0), .addr_sel_pin1_in(pin1), .addr_sel_pin2_in(pin2),
        .chan_12v_a_on_in(chan_a), .chan_12v_b_on_in(chan_b),
        .bleed_en_12v_a_out(en_a), .bleed_en_12v_b_out(en_b),
        .bleed_sw_12v_a_out(sw_a), .bleed_sw_12v_b_out(sw_b),
        .dev_addr_out(dev_addr)
    );

    tlas_i2c_master_model u_tlas_i2c_master_model (
        .scl_out(scl), .sda_pull_out(sda_pull), .sda_in(sda_wire)
    );

    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    function automatic tlas_tri_pin_type pin_code(input int lvl);
        return (lvl == 0) ? 2'b01 : ((lvl == 2) ? 2'b10 : 2'b00);
    endfunction

    function automatic logic [6:0] exp_addr(input int p2, input int p1, input int p0);
        return 7'(8 + 9 * p2 + 3 * p1 + p0);
    endfunction

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("unexpected at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask

    task automatic close_out();
        if (fail_count == 0 && num_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task automatic set_pins(input int p2, input int p1, input int p0);
        @(posedge clk_in);
        #2;
        pin2 = pin_code(p2);
        pin1 = pin_code(p1);
        pin0 = pin_code(p0);
        repeat (6) @(posedge clk_in);
        #2;
    endtask

    initial begin
        clk_in = 1'b0;
        forever #25 clk_in = ~clk_in;
    end

    initial begin
        repeat (90000) @(posedge clk_in);
        fail_count++;
        close_out();
    end

    initial begin
        rst_in = 1'b1;
        pin0 = pin_code(0);
        pin1 = pin_code(0);
        pin2 = pin_code(0);
        chan_a = 1'b0;
        chan_b = 1'b0;
        fail_count = 0;
        num_checks = 0;
        lfsr_state = 32'hB04CB5F9;
        repeat (5) @(posedge clk_in);
        check(dev_addr, ADDR_BASE);
        check({en_a, en_b, sw_a, sw_b, sda_oe}, 5'h00);
        check(sda_out, 1'b0);
        #2 rst_in = 1'b0;
        // Every pin level combination
        for (k = 0; k < 27; k++) begin
            set_pins(k / 9, (k / 3) % 3, k % 3);
            check(dev_addr, exp_addr(k / 9, (k / 3) % 3, k % 3));
        end
        for (k = 0; k < 6; k++) begin
            lfsr_state = lfsr_next(lfsr_state);
            r = lfsr_state;
            l2 = r[1:0] % 3;
            l1 = r[3:2] % 3;
            l0 = r[5:4] % 3;
            set_pins(l2, l1, l0);
            a = exp_addr(l2, l1, l0);
            num = {5'h00, r[10:8]};
            dat = r[23:16];
            u_tlas_i2c_master_model.write_reg(a, num, dat, acks);
            check(acks, 3'h7);
            u_tlas_i2c_master_model.read_reg(a, num, got, acks);
            check(acks, 3'h7);
            check(got, dat);
            check({sda_out, sda_oe}, 2'h0);
        end
        // Last register, out-of-range register, foreign address
        u_tlas_i2c_master_model.write_reg(a, 8'h07, 8'hA5, acks);
        check(acks, 3'h7);
        u_tlas_i2c_master_model.write_reg(a, 8'h08, 8'h5A, acks);
        check(acks, 3'h7);
        u_tlas_i2c_master_model.read_reg(a, 8'h08, got, acks);
        check(got, 8'h00);
        u_tlas_i2c_master_model.write_reg(a ^ 7'h40, 8'h07, 8'h3C, acks);
        check(acks, 3'h0);
        u_tlas_i2c_master_model.read_reg(a, 8'h07, got, acks);
        check(got, 8'hA5);
        // Bleed enables and switches
        for (k = 0; k < 4; k++) begin
            u_tlas_i2c_master_model.write_reg(a, REG_BLEED_A, tab_r1[k], acks);
            u_tlas_i2c_master_model.write_reg(a, REG_BLEED_B, tab_r4[k], acks);
            @(posedge clk_in);
            #2;
            chan_a = tab_ca[k];
            chan_b = tab_cb[k];
            repeat (4) @(posedge clk_in);
            #2;
            check({en_a, en_b}, {tab_r1[k][7], tab_r4[k][7]});
            check({sw_a, sw_b}, {tab_r1[k][7] & ~tab_ca[k], tab_r4[k][7] & ~tab_cb[k]});
        end
        close_out();
    end
endmodule
`default_nettype wire
